// ==== core/aspm_pkg.sv ====
// Purpose: Shared types and constants of the asynchronous serial port.
// Assumes: One core clock; timer 1 overflow arrives as a one-cycle pulse on it.
// Notes: The framed modes run sixteen bit-rate ticks per bit.
package aspm_pkg;

	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;

	// Sixteen ticks per bit in the framed modes.
	localparam logic [3:0] TICKS_LAST = 4'hf;
	// Tick count at which the start bit is checked again near its middle.
	localparam logic [3:0] START_CHECK = 4'h7;
	// Bits on the line per frame: 8-bit mode, 9-bit modes, shift mode.
	localparam logic [3:0] FRAME8_BITS = 4'ha;
	localparam logic [3:0] FRAME9_BITS = 4'hb;
	localparam logic [3:0] SHIFT_BITS = 4'h8;
	// Samples taken after the start bit up to the final shift pulse.
	localparam logic [3:0] RX_SAMPLES = 4'h9;
	// Shift mode: one bit per twelve core clocks.
	localparam logic [3:0] MODE0_DIV_LAST = 4'hb;
	// Fixed 9-bit mode: a tick each four clocks gives the core clock over 64.
	localparam logic [1:0] MODE2_DIV_LAST = 2'h3;
	// Timer 2 rolls over after this count.
	localparam logic [15:0] T2_LAST = 16'hffff;

	typedef enum logic [1:0] {
		MODE_SHIFT = 2'h0,
		MODE_8VAR = 2'h1,
		MODE_9FIX = 2'h2,
		MODE_9VAR = 2'h3
	} aspm_mode_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_SYNC = 2'h1,
		TX_SHIFT = 2'h3
	} aspm_tx_st_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_START = 2'h1,
		RX_DATA = 2'h3,
		RX_STOP = 2'h2
	} aspm_rx_st_t;

	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic multiproc_filter;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rate_double_bit;
		logic tx_clock_select;
		logic rx_clock_select;
		logic [7:0] timer2_reload_high;
		logic [7:0] timer2_reload_low;
	} aspm_cfg_t;

endpackage

// ==== core/aspm_serial_port.sv ====
// Purpose: Asynchronous serial port with its framed modes and bit-rate sources.
// Assumes: Control bits come from logic on clk_i; only rxd_i is asynchronous.
// Notes: Writes queue in a sixteen-word buffer ahead of the transmitter.
// What this block does
// - 8-bit mode frame: start, eight LSB-first, stop.
// - 8-bit mode rate from timer 1 or 2.
// - Buffer write starts sending; ninth position is 1.
// - Shift bits out; flag when stop starts.
// - Falling input edge starts reception, start dropped.
// - Accept only if flag clear and filter passes.
// - Rejected frames leave buffer and flag untouched.
// - 9-bit modes send eleven bits with ninth.
// - Fixed 9-bit rate: clock over 64 or 32.
// - Start copies data and ninth bit into shifter.
// - First bit waits for next bit-rate clock.
// - 9-bit accept stores data and ninth bit.
// - Mode three: 9-bit frames, timer-driven rate.
// - Writes send unless the queue is full; reception needs receive enable.
// - Shift mode rate is clock over twelve.
// - Timer 1 rate: overflows times doubling over 32.
// - Sixteen timer 2 overflows make one bit.
// - Timer 2 counts every second core clock.
// - Clock selects put timer 2 in baud use.
// - Timer 2 reloads from its reload pair.
// - Transmit writes and receive reads are separate.
// - Timer 2 overflow flag blocked during baud use.

module aspm_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_rdy;
		logic out_vld;
	} aspm_fifo_st_t;

	aspm_fifo_st_t s_r;
	aspm_fifo_st_t s_nxt;

	always_comb begin
		logic push;
		logic pop;
		push = in_valid_i && s_r.in_rdy;
		pop = out_ready_i && s_r.out_vld;
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// Flags are registered so the ready seen by the writer has no long path.
		s_nxt.in_rdy = s_nxt.cnt != CNT_FULL;
		s_nxt.out_vld = s_nxt.cnt != '0;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_r <= '0;
			s_r.in_rdy <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign in_ready_o = s_r.in_rdy;
	assign out_valid_o = s_r.out_vld;
	assign out_data_o = s_r.mem[s_r.rp];
endmodule // aspm_fifo

module aspm_serial_port
	import aspm_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire aspm_cfg_t cfg_i,
	input wire logic timer1_overflow_i,
	input wire logic serial_buffer_wr_i,
	input wire logic [7:0] serial_buffer_wdata_i,
	output logic tx_ready_o,
	input wire logic tx_flag_clr_i,
	input wire logic rx_flag_clr_i,
	input wire logic rxd_i,
	output logic txd_o,
	output logic [7:0] serial_buffer_rdata_o,
	output logic rx_ninth_bit_o,
	output logic tx_complete_flag_o,
	output logic rx_complete_flag_o,
	output logic timer2_flag_block_o
);

	typedef struct packed {
		logic rx_m;
		logic rx_s;
		logic rx_p;
		logic [3:0] m0_cnt;
		logic [1:0] m2_cnt;
		logic t1_half;
		logic t2_pre;
		logic [15:0] t2_cnt;
		logic t2_blk;
		aspm_tx_st_t tx_st;
		logic [3:0] tx_div;
		logic [3:0] tx_cnt;
		logic [10:0] tx_sh;
		logic txd;
		logic tx_flag;
		aspm_rx_st_t rx_st;
		logic [3:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [8:0] rx_sh;
		logic [7:0] rbuf;
		logic rx9;
		logic rx_flag;
	} aspm_state_t;

	aspm_state_t s_r;
	aspm_state_t s_nxt;

	aspm_mode_t mode;
	logic framed;
	logic m0_tick;
	logic m2_tick;
	logic t1_tick;
	logic t2_en;
	logic t2_tick;
	logic [15:0] t2_reload;
	logic tx_tick;
	logic rx_tick;
	logic tx_bnd;
	logic [3:0] tx_last;
	logic tx_ninth;
	logic rx_fall;
	logic fifo_vld;
	logic fifo_pop;
	logic [7:0] fifo_data;

	// Writes land in the transmit queue; reads see only the receive buffer.
	aspm_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.in_valid_i(serial_buffer_wr_i),
		.in_data_i(serial_buffer_wdata_i),
		.in_ready_o(tx_ready_o),
		.out_valid_o(fifo_vld),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	assign mode = aspm_mode_t'({cfg_i.mode_select_high, cfg_i.mode_select_low});
	assign framed = mode != MODE_SHIFT;
	assign m0_tick = s_r.m0_cnt == MODE0_DIV_LAST;
	assign m2_tick = cfg_i.rate_double_bit ? s_r.m2_cnt[0] : (s_r.m2_cnt == MODE2_DIV_LAST);
	// Without doubling only every second timer 1 overflow counts.
	assign t1_tick = timer1_overflow_i && (cfg_i.rate_double_bit || s_r.t1_half);
	assign t2_en = cfg_i.tx_clock_select || cfg_i.rx_clock_select;
	assign t2_tick = t2_en && s_r.t2_pre && (s_r.t2_cnt == T2_LAST);
	assign t2_reload = {cfg_i.timer2_reload_high, cfg_i.timer2_reload_low};
	// Each direction picks its own timer.
	assign tx_tick = (mode == MODE_9FIX) ? m2_tick : (cfg_i.tx_clock_select ? t2_tick : t1_tick);
	assign rx_tick = (mode == MODE_9FIX) ? m2_tick : (cfg_i.rx_clock_select ? t2_tick : t1_tick);
	// The divider runs free, so a new frame waits for the next bit-rate clock.
	assign tx_bnd = framed ? (tx_tick && (s_r.tx_div == TICKS_LAST)) : m0_tick;
	assign tx_last = !framed ? SHIFT_BITS : ((mode == MODE_8VAR) ? FRAME8_BITS : FRAME9_BITS);
	assign tx_ninth = (mode == MODE_8VAR) ? 1'b1 : cfg_i.tx_ninth_bit;
	assign rx_fall = s_r.rx_p && !s_r.rx_s;
	assign fifo_pop = (s_r.tx_st == TX_IDLE) && fifo_vld;

	always_comb begin
		logic tx_set;
		logic rx_set;
		tx_set = 1'b0;
		rx_set = 1'b0;
		s_nxt = s_r;
		s_nxt.rx_m = rxd_i;
		s_nxt.rx_s = s_r.rx_m;
		s_nxt.rx_p = s_r.rx_s;
		s_nxt.m0_cnt = m0_tick ? 4'h0 : (s_r.m0_cnt + 4'h1);
		s_nxt.m2_cnt = s_r.m2_cnt + 2'h1;
		if (timer1_overflow_i) begin
			s_nxt.t1_half = !s_r.t1_half;
		end
		s_nxt.t2_blk = t2_en;
		if (t2_en) begin
			s_nxt.t2_pre = !s_r.t2_pre;
			if (s_r.t2_pre) begin
				s_nxt.t2_cnt = t2_tick ? t2_reload : (s_r.t2_cnt + 16'h1);
			end
		end else begin
			// Parked at the reload value, so the first bit after enabling is not a whole count late.
			s_nxt.t2_cnt = t2_reload;
		end

		if (tx_tick) begin
			s_nxt.tx_div = s_r.tx_div + 4'h1;
		end
		case (s_r.tx_st)
			TX_IDLE: begin
				if (fifo_vld) begin
					if (framed) begin
						s_nxt.tx_sh = {1'b1, tx_ninth, fifo_data, 1'b0};
					end else begin
						s_nxt.tx_sh = {3'h7, fifo_data};
					end
					s_nxt.tx_cnt = 4'h0;
					s_nxt.tx_st = TX_SYNC;
				end
			end
			TX_SYNC, TX_SHIFT: begin
				if (tx_bnd) begin
					if (s_r.tx_cnt == tx_last) begin
						s_nxt.tx_st = TX_IDLE;
						s_nxt.txd = 1'b1;
						tx_set = !framed;
					end else begin
						s_nxt.txd = s_r.tx_sh[0];
						s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
						s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
						s_nxt.tx_st = TX_SHIFT;
						tx_set = framed && (s_r.tx_cnt == tx_last - 4'h1);
					end
				end
			end
			default: begin
				s_nxt.tx_st = TX_IDLE;
			end
		endcase
		// A completion in the clearing cycle keeps the flag set.
		s_nxt.tx_flag = (s_r.tx_flag && !tx_flag_clr_i) || tx_set;

		case (s_r.rx_st)
			RX_IDLE: begin
				if (framed && cfg_i.rx_enable && rx_fall) begin
					s_nxt.rx_st = RX_START;
					s_nxt.rx_cnt = 4'h0;
				end
			end
			RX_START: begin
				if (rx_tick) begin
					s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
					if (s_r.rx_cnt == START_CHECK) begin
						s_nxt.rx_cnt = 4'h0;
						s_nxt.rx_bits = 4'h0;
						s_nxt.rx_st = s_r.rx_s ? RX_IDLE : RX_DATA;
					end
				end
			end
			RX_DATA: begin
				if (rx_tick) begin
					s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
					if (s_r.rx_cnt == TICKS_LAST) begin
						s_nxt.rx_sh = {s_r.rx_s, s_r.rx_sh[8:1]};
						s_nxt.rx_bits = s_r.rx_bits + 4'h1;
						if (s_r.rx_bits == RX_SAMPLES - 4'h1) begin
							s_nxt.rx_st = (mode == MODE_8VAR) ? RX_IDLE : RX_STOP;
							// Ninth sample is the stop bit in 8-bit mode.
							if (!s_r.rx_flag && (!cfg_i.multiproc_filter || s_r.rx_s)) begin
								s_nxt.rbuf = s_nxt.rx_sh[7:0];
								s_nxt.rx9 = s_r.rx_s;
								rx_set = 1'b1;
							end
						end
					end
				end
			end
			RX_STOP: begin
				if (rx_tick) begin
					s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
					if (s_r.rx_cnt == TICKS_LAST) begin
						s_nxt.rx_st = RX_IDLE;
					end
				end
			end
			default: begin
				s_nxt.rx_st = RX_IDLE;
			end
		endcase
		s_nxt.rx_flag = (s_r.rx_flag && !rx_flag_clr_i) || rx_set;
	end

	// The line and synchroniser reset high so no false start is seen.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_r <= '0;
			s_r.txd <= 1'b1;
			s_r.rx_m <= 1'b1;
			s_r.rx_s <= 1'b1;
			s_r.rx_p <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign txd_o = s_r.txd;
	assign serial_buffer_rdata_o = s_r.rbuf;
	assign rx_ninth_bit_o = s_r.rx9;
	assign tx_complete_flag_o = s_r.tx_flag;
	assign rx_complete_flag_o = s_r.rx_flag;
	assign timer2_flag_block_o = s_r.t2_blk;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_tx_start;
		(s_r.tx_st == TX_SYNC) && tx_bnd && ce_i && framed |=> !txd_o;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not low");

	property p_tx_flag_stop;
		$rose(tx_complete_flag_o) && $past(framed) |-> txd_o && (s_r.tx_st == TX_SHIFT);
	endproperty
	a_tx_flag_stop: assert property (p_tx_flag_stop) else $error("flag not at stop bit");

	property p_tx_sync_idle;
		(s_r.tx_st == TX_SYNC) |-> txd_o;
	endproperty
	a_tx_sync_idle: assert property (p_tx_sync_idle) else $error("bit driven before rate clock");

	property p_rx_keep;
		rx_complete_flag_o && !rx_flag_clr_i |=> $stable(serial_buffer_rdata_o) && rx_complete_flag_o;
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("receive buffer overwritten");

	property p_rx_filter;
		$rose(rx_complete_flag_o) && $past(cfg_i.multiproc_filter) |-> rx_ninth_bit_o;
	endproperty
	a_rx_filter: assert property (p_rx_filter) else $error("filtered frame accepted");

	property p_rx_off;
		(s_r.rx_st == RX_IDLE) && !cfg_i.rx_enable |=> (s_r.rx_st == RX_IDLE);
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("reception while disabled");

	property p_rx_false_start;
		(s_r.rx_st == RX_START) && rx_tick && ce_i && (s_r.rx_cnt == START_CHECK) && s_r.rx_s
			|=> (s_r.rx_st == RX_IDLE);
	endproperty
	a_rx_false_start: assert property (p_rx_false_start) else $error("false start kept");

	property p_mode2_rate;
		((mode == MODE_9FIX) && !cfg_i.rate_double_bit && m2_tick && ce_i ##1 (ce_i && !cfg_i.rate_double_bit) [*2])
			|-> !m2_tick && !$past(m2_tick);
	endproperty
	a_mode2_rate: assert property (p_mode2_rate) else $error("fixed rate wrong");

	property p_t2_reload;
		t2_tick && ce_i |=> (s_r.t2_cnt == $past(t2_reload));
	endproperty
	a_t2_reload: assert property (p_t2_reload) else $error("timer 2 reload missed");

endmodule // aspm_serial_port

// ==== dv/aspm_remote_node.sv ====
// Purpose: Remote serial node facing the port's line pins.
// Assumes: The bench gives the bit time in core clocks and the frame length.
// Notes: Sampling at mid-bit means a wrong bit rate shows up as wrong bits.
module aspm_remote_node (
	input wire logic clk_i,
	input wire logic txd_i,
	input wire logic [15:0] bit_clks_i,
	input wire logic nine_i,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] got_q[$];
	logic [10:0] f;
	initial rxd_o = 1'b1;
	always begin
		@(negedge txd_i);
		f = '0;
		repeat (bit_clks_i / 2) @(negedge clk_i);
		for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
			f[i] = txd_i;
			if (i < (nine_i ? 10 : 9)) repeat (bit_clks_i) @(negedge clk_i);
		end
		got_q.push_back(f);
	end
	task automatic send(input logic [10:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i);
			rxd_o = fr[i];
			repeat (bit_clks_i - 1) @(negedge clk_i);
		end
		@(negedge clk_i);
		rxd_o = 1'b1;
		repeat (bit_clks_i) @(negedge clk_i);
	endtask
	// A short low pulse that must not be taken for a start bit.
	task automatic glitch();
		@(negedge clk_i);
		rxd_o = 1'b0;
		repeat (3) @(negedge clk_i);
		rxd_o = 1'b1;
		repeat (bit_clks_i) @(negedge clk_i);
	endtask
endmodule // aspm_remote_node

// ==== dv/test_async_serial_port_modes.sv ====
// Purpose: Self-checking bench of the serial port in its framed modes and its shift mode.
// Assumes: Control bits change only while the line is idle.
// Notes: Clock enable drops once while the port is idle, to show a frozen write is not taken.
module test_async_serial_port_modes
	import aspm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] MD [6] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h1, 2'h3};
	localparam logic DB [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
	localparam logic SL [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	localparam logic [15:0] BC [6] = '{16'h20, 16'h40, 16'h40, 16'h40, 16'h80, 16'h40};
	logic clk, nrst, wr, t1ovf, txclr, rxclr, nine, txd, rdy, r9, tflag, rflag, blk, rxd, er9, ef, ce;
	logic [7:0] wdata, rd, erd;
	logic [15:0] bclk;
	logic [1:0] t1c, m;
	aspm_cfg_t cfg;
	int fail_count, num_checks, cyc, seed, refused;
	logic [10:0] exp_q[$];
	aspm_serial_port i_aspm_serial_port (.clk_i(clk), .nrst_i(nrst), .ce_i(ce), .cfg_i(cfg),
		.timer1_overflow_i(t1ovf), .serial_buffer_wr_i(wr), .serial_buffer_wdata_i(wdata), .tx_ready_o(rdy),
		.tx_flag_clr_i(txclr), .rx_flag_clr_i(rxclr), .rxd_i(rxd), .txd_o(txd), .serial_buffer_rdata_o(rd),
		.rx_ninth_bit_o(r9), .tx_complete_flag_o(tflag), .rx_complete_flag_o(rflag), .timer2_flag_block_o(blk));
	aspm_remote_node i_aspm_remote_node (.clk_i(clk), .txd_i(txd), .bit_clks_i(bclk), .nine_i(nine), .rxd_o(rxd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Timer 1 runs as an auto-reload timer overflowing every fourth clock.
	always @(negedge clk) begin
		t1c <= t1c + 2'h1;
		t1ovf <= (t1c == 2'h3);
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			fail_count++;
			report_and_stop();
		end
	end
	function automatic logic [10:0] frm(input logic [7:0] d, input logic n9, input logic nn);
		return nn ? {1'b1, n9, d, 1'b0} : {2'b01, d, 1'b0};
	endfunction
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic setup(input logic [1:0] md, input logic dbl, input logic sel, input logic [15:0] bc);
		@(negedge clk);
		{cfg.mode_select_high, cfg.mode_select_low} = md;
		cfg.rate_double_bit = dbl;
		cfg.tx_clock_select = sel;
		bclk = bc;
		nine = md[1];
	endtask
	// Writes go in on every clock; a write while the queue is full is lost.
	task automatic burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			wr = 1'b1;
			wdata = 8'($random(seed));
			if (rdy === 1'b1) exp_q.push_back(frm(wdata, cfg.tx_ninth_bit, nine));
			else refused++;
		end
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic drain();
		int k;
		k = 0;
		while (i_aspm_remote_node.got_q.size() < exp_q.size() && k < 40000) begin
			@(negedge clk);
			k++;
		end
		while (exp_q.size() > 0) begin
			chk(i_aspm_remote_node.got_q.size() > 0 ? i_aspm_remote_node.got_q.pop_front() : 11'h7ff,
				exp_q.pop_front());
		end
	endtask
	task automatic clr(input logic t);
		@(negedge clk);
		if (t) txclr = 1'b1;
		else rxclr = 1'b1;
		@(negedge clk);
		txclr = 1'b0;
		rxclr = 1'b0;
	endtask
	task automatic rxf(input logic [7:0] d, input logic n9);
		logic ok;
		ok = cfg.rx_enable && !ef && (!cfg.multiproc_filter || !nine || n9);
		if (seed[0]) i_aspm_remote_node.glitch();
		i_aspm_remote_node.send(frm(d, n9, nine), nine ? 11 : 10);
		if (ok) begin
			erd = d;
			er9 = nine ? n9 : 1'b1;
			ef = 1'b1;
		end
		chk({rflag, r9, rd}, {ef, er9, erd});
	endtask
	initial begin
		seed = 32'h0361810f;
		nrst = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		txclr = 1'b0;
		rxclr = 1'b0;
		wdata = 8'h0;
		cfg = '0;
		cfg.timer2_reload_high = 8'hff;
		cfg.timer2_reload_low = 8'hfe;
		t1c = 2'h0;
		t1ovf = 1'b0;
		bclk = 16'h20;
		nine = 1'b0;
		ef = 1'b0;
		er9 = 1'b0;
		erd = 8'h0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk({txd, rdy, tflag, rflag, rd, r9}, 13'h1800);
		for (int i = 0; i < 6; i++) begin
			setup(MD[i], DB[i], SL[i], BC[i]);
			cfg.tx_ninth_bit = 1'($random(seed));
			burst(2);
			drain();
			chk(blk, SL[i]);
			chk({rflag, r9, rd}, {ef, er9, erd});
			chk(tflag, 1'b1);
			clr(1'b1);
			chk(tflag, 1'b0);
		end
		// A write while the clock enable is low must leave no trace.
		@(negedge clk);
		ce = 1'b0;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		repeat (3) @(negedge clk);
		chk({rdy, tflag, txd}, 3'h5);
		ce = 1'b1;
		repeat (1000) @(negedge clk);
		chk(i_aspm_remote_node.got_q.size() != 0, 1'b0);
		// Overfill the queue while the line drains it slowly.
		setup(2'h2, 1'b1, 1'b0, 16'h20);
		burst(20);
		chk(refused != 0, 1'b1);
		drain();
		// Shift mode: eight bits at twelve clocks each, first bit low so the node sees it.
		clr(1'b1);
		setup(2'h0, 1'b0, 1'b0, 16'h0c);
		@(negedge clk);
		wr = 1'b1;
		wdata = {7'($random(seed)), 1'b0};
		exp_q.push_back({3'h3, wdata});
		@(negedge clk);
		wr = 1'b0;
		drain();
		chk(tflag, 1'b1);
		for (int i = 0; i < 14; i++) begin
			m = 2'($random(seed));
			if (m == 2'h0) m = 2'h1;
			setup(m, 1'b1, 1'b0, m == 2'h2 ? 16'h20 : 16'h40);
			cfg.rx_enable = (i % 5 != 4);
			cfg.multiproc_filter = i[1];
			if (i % 3 == 2) begin
				clr(1'b0);
				ef = 1'b0;
			end
			rxf(8'($random(seed)), 1'($random(seed)));
		end
		report_and_stop();
	end
endmodule // test_async_serial_port_modes
